// ### design/gpa_pkg.sv
// package: shared constants and carrier structs for the protection aggregator
package gpa_pkg;
    localparam int NUM_ELEMENTS      = 4;
    localparam int NUM_PHASES        = 3;
    localparam int NUM_BREAKERS      = 2;
    localparam int DELAY_WIDTH       = 16;
    localparam logic [15:0] DELAY_RESET_VALUE = 16'h0000;
    localparam logic [3:0]  EVENTS_RESET      = 4'h0;

    // global protection settings
    typedef struct packed {
        logic function_active;
        logic external_block_permit;
        logic trip_order_perm_block;
        logic trip_order_ext_block_permit;
    } gpa_global_cfg_s;

    // temporary blocking inputs
    typedef struct packed {
        logic block_input_a;
        logic block_input_b;
        logic trip_order_block_input;
    } gpa_block_in_s;

    // collective outputs
    typedef struct packed {
        logic                  alarm;
        logic                  trip;
        logic [NUM_PHASES-1:0] alarm_phase;
        logic [NUM_PHASES-1:0] trip_phase;
    } gpa_collective_s;

    // event status bits
    localparam int EV_ALARM  = 0;
    localparam int EV_TRIP   = 1;
    localparam int EV_ORDER  = 2;
    localparam int EV_BLOCK  = 3;
    localparam int NUM_EVENTS = 4;
endpackage

// ### design/gpa_element.sv
// file: one protection element with alarm, delay timer and trip
`timescale 1ns/1ps
module gpa_element #(
    parameter int DW = gpa_pkg::DELAY_WIDTH
) (
    input  wire logic          clk_in,
    input  wire logic          rstn_in,
    input  wire logic          enable_in,
    input  wire logic          fault_in,
    input  wire logic [DW-1:0] delay_in,
    output logic               alarm_out,
    output logic               trip_out
);
    typedef struct packed {
        logic [DW-1:0] count;
        logic          alarm;
        logic          trip;
    } gpa_elem_state_s;

    gpa_elem_state_s state_q;
    gpa_elem_state_s state_d;

    always_comb begin
        state_d = state_q;
        state_d.alarm = enable_in && fault_in;
        if (!enable_in || !fault_in) begin
            state_d.count = '0;
            state_d.trip  = 1'b0;
        end else if (state_q.count >= delay_in) begin
            state_d.trip = 1'b1;
        end else begin
            state_d.count = state_q.count + 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign alarm_out = state_q.alarm;
    assign trip_out  = state_q.trip;

    trip_needs_fault_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        trip_out |-> $past(fault_in) && $past(enable_in))
        else $error("trip without fault");
    trip_clears_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        !fault_in |=> !trip_out)
        else $error("trip held after fault cleared");
    alarm_follows_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (fault_in && enable_in) |=> alarm_out)
        else $error("alarm missing");
endmodule

// ### design/gpa_route.sv
// file: per-breaker trip routing stage
`timescale 1ns/1ps
module gpa_route #(
    parameter int NE = gpa_pkg::NUM_ELEMENTS
) (
    input  wire logic          clk_in,
    input  wire logic          rstn_in,
    input  wire logic [NE-1:0] trip_order_in,
    input  wire logic [NE-1:0] assign_in,
    output logic               breaker_trip_out
);
    logic breaker_q;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            breaker_q <= 1'b0;
        end else begin
            breaker_q <= |(trip_order_in & assign_in);
        end
    end

    assign breaker_trip_out = breaker_q;

    breaker_route_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        |(trip_order_in & assign_in) |=> breaker_trip_out)
        else $error("assigned trip order not routed");
endmodule

// ### design/gpa_aggregator.sv
// file: top level of the general protection aggregator
//
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module gpa_aggregator #(
    parameter int NE = gpa_pkg::NUM_ELEMENTS,
    parameter int NP = gpa_pkg::NUM_PHASES,
    parameter int NB = gpa_pkg::NUM_BREAKERS,
    parameter int DW = gpa_pkg::DELAY_WIDTH
) (
    input  wire logic                       clk_in,
    input  wire logic                       rstn_in,
    input  wire gpa_pkg::gpa_global_cfg_s   global_cfg_in,
    input  wire gpa_pkg::gpa_block_in_s     block_in,
    input  wire logic [NE-1:0]              elem_function_in,
    input  wire logic [NE-1:0]              elem_superv_only_in,
    input  wire logic [NE-1:0]              elem_single_phase_in,
    input  wire logic [NE-1:0]              elem_trip_order_perm_block_in,
    input  wire logic [NE-1:0]              elem_trip_order_block_input_in,
    input  wire logic [NE-1:0]              fault_in,
    input  wire logic [NE*NP-1:0]           fault_phase_in,
    input  wire logic [NE*DW-1:0]           delay_in,
    input  wire logic [NB*NE-1:0]           breaker_assign_in,
    input  wire logic [7:0]                 reg_addr_in,
    input  wire logic [31:0]                reg_wdata_in,
    input  wire logic                       reg_write_in,
    input  wire logic                       reg_read_in,
    output logic [31:0]                     reg_rdata_out,
    output logic [NE-1:0]                   elem_alarm_out,
    output logic [NE-1:0]                   elem_trip_out,
    output logic [NE-1:0]                   trip_order_out,
    output gpa_pkg::gpa_collective_s        collective_out,
    output logic                            protection_blocked_out,
    output logic [NB-1:0]                   breaker_trip_out,
    output logic                            irq_out
);
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_MASK   = 8'h04;
    localparam logic [7:0] ADDR_LIVE   = 8'h08;
    localparam int         EW          = gpa_pkg::NUM_EVENTS;

    typedef struct packed {
        gpa_pkg::gpa_collective_s coll;
        logic [NE-1:0]            order;
        logic [NE-1:0]            elem_alarm;
        logic [NE-1:0]            elem_trip;
        logic                     blocked;
        logic [EW-1:0]            status;
        logic [EW-1:0]            mask;
        logic [31:0]              rdata;
        logic                     irq;
    } gpa_top_state_s;

    gpa_top_state_s state_q;
    gpa_top_state_s state_d;

    logic [NE-1:0] raw_alarm;
    logic [NE-1:0] raw_trip;
    logic [NE-1:0] elem_enable;
    logic [NE-1:0] contrib;
    logic [NE-1:0] phase_ok;
    logic          master_block;
    logic          order_block;
    logic [EW-1:0] events;

    // temporary block is gated by its permit
    always_comb begin
        master_block = !global_cfg_in.function_active
            || (global_cfg_in.external_block_permit
                && (block_in.block_input_a || block_in.block_input_b));
        order_block = global_cfg_in.trip_order_perm_block
            || (global_cfg_in.trip_order_ext_block_permit
                && block_in.trip_order_block_input);
        elem_enable = master_block ? '0 : elem_function_in;
        contrib     = ~elem_superv_only_in;
        phase_ok    = contrib & elem_single_phase_in;
    end

    generate
        for (genvar e = 0; e < NE; e++) begin : g_elem
            gpa_element #(
                .DW(DW)
            ) u_elem (
                .clk_in    (clk_in),
                .rstn_in   (rstn_in),
                .enable_in (elem_enable[e]),
                .fault_in  (fault_in[e]),
                .delay_in  (delay_in[e*DW +: DW]),
                .alarm_out (raw_alarm[e]),
                .trip_out  (raw_trip[e])
            );
        end
        for (genvar b = 0; b < NB; b++) begin : g_brk
            gpa_route #(
                .NE(NE)
            ) u_route (
                .clk_in           (clk_in),
                .rstn_in          (rstn_in),
                .trip_order_in    (state_q.order),
                .assign_in        (breaker_assign_in[b*NE +: NE]),
                .breaker_trip_out (breaker_trip_out[b])
            );
        end
    endgenerate

    // phase or-reduction across elements, used for alarms and trips
    function automatic logic [NP-1:0] phase_or(input logic [NE-1:0] act,
                                               input logic [NE*NP-1:0] ph);
        logic [NP-1:0] r;
        r = '0;
        for (int e = 0; e < NE; e++) begin
            if (act[e]) begin
                r = r | ph[e*NP +: NP];
            end
        end
        return r;
    endfunction

    always_comb begin
        state_d = state_q;
        // an element just disabled must not leak its last registered state
        state_d.elem_alarm = raw_alarm & elem_enable;
        state_d.elem_trip  = raw_trip & elem_enable;
        state_d.coll.alarm = |(state_d.elem_alarm & contrib);
        state_d.coll.trip  = |(state_d.elem_trip & contrib);
        state_d.coll.alarm_phase = phase_or(state_d.elem_alarm & phase_ok,
                                            fault_phase_in);
        state_d.coll.trip_phase  = phase_or(state_d.elem_trip & phase_ok,
                                            fault_phase_in);
        state_d.order = (order_block ? '0
            : state_d.elem_trip & contrib
              & ~elem_trip_order_perm_block_in
              & ~elem_trip_order_block_input_in);
        state_d.blocked = master_block;
        events[gpa_pkg::EV_ALARM] = state_d.coll.alarm && !state_q.coll.alarm;
        events[gpa_pkg::EV_TRIP]  = state_d.coll.trip && !state_q.coll.trip;
        events[gpa_pkg::EV_ORDER] = (|state_d.order) && !(|state_q.order);
        events[gpa_pkg::EV_BLOCK] = master_block && !state_q.blocked;
        // set wins over a write-one clear in the same cycle
        if (reg_write_in && reg_addr_in == ADDR_STATUS) begin
            state_d.status = (state_q.status & ~reg_wdata_in[EW-1:0]) | events;
        end else begin
            state_d.status = state_q.status | events;
        end
        if (reg_write_in && reg_addr_in == ADDR_MASK) begin
            state_d.mask = reg_wdata_in[EW-1:0];
        end
        state_d.rdata = '0;
        if (reg_read_in) begin
            if (reg_addr_in == ADDR_STATUS) begin
                state_d.rdata = {{(32-EW){1'b0}}, state_q.status};
            end else if (reg_addr_in == ADDR_MASK) begin
                state_d.rdata = {{(32-EW){1'b0}}, state_q.mask};
            end else if (reg_addr_in == ADDR_LIVE) begin
                state_d.rdata = {29'h0000_0000, state_q.blocked,
                                 state_q.coll.trip, state_q.coll.alarm};
            end else begin
                state_d.rdata = '0;
            end
        end
        state_d.irq = |(state_d.status & state_d.mask);
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign reg_rdata_out          = state_q.rdata;
    assign elem_alarm_out         = state_q.elem_alarm;
    assign elem_trip_out          = state_q.elem_trip;
    assign trip_order_out         = state_q.order;
    assign collective_out         = state_q.coll;
    assign protection_blocked_out = state_q.blocked;
    assign irq_out                = state_q.irq;

    master_off_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (!global_cfg_in.function_active ##1 !global_cfg_in.function_active)
        |=> !collective_out.alarm && !collective_out.trip)
        else $error("protection active while master off");
    permit_gate_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (global_cfg_in.function_active && !global_cfg_in.external_block_permit)
        |=> !protection_blocked_out)
        else $error("block without permit");
    ext_block_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (global_cfg_in.external_block_permit && block_in.block_input_b)
        |=> protection_blocked_out)
        else $error("block input ignored");
    perm_order_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        $past(global_cfg_in.trip_order_perm_block) |-> trip_order_out == '0)
        else $error("trip order despite permanent block");
    temp_order_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        $past(global_cfg_in.trip_order_ext_block_permit
              && block_in.trip_order_block_input) |-> trip_order_out == '0)
        else $error("trip order despite temporary block");
    superv_order_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        |(trip_order_out & $past(elem_superv_only_in)) == 1'b0)
        else $error("supervision element issued trip order");
    coll_alarm_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        collective_out.alarm == |(elem_alarm_out & ~$past(elem_superv_only_in)))
        else $error("collective alarm mismatch");
    coll_trip_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        collective_out.trip == |(elem_trip_out & ~$past(elem_superv_only_in)))
        else $error("collective trip mismatch");
    phase_sub_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (|collective_out.trip_phase) |-> collective_out.trip)
        else $error("phase trip without general trip");
endmodule

// ### dv/gpa_fault_src.sv
// partner: protection element fault sources feeding the aggregator
`timescale 1ns/1ps
module gpa_fault_src #(
    parameter int NE = gpa_pkg::NUM_ELEMENTS,
    parameter int NP = gpa_pkg::NUM_PHASES
) (
    input  wire logic           clk_in,
    output logic [NE-1:0]       fault_out,
    output logic [NE*NP-1:0]    fault_phase_out
);
    // criteria are levels; phase field cleared with the fault so no stale phase lingers
    initial begin
        fault_out       = '0;
        fault_phase_out = '0;
    end

    task automatic raise(input int e, input logic [NP-1:0] ph);
        @(posedge clk_in);
        fault_out[e]              <= 1'b1;
        fault_phase_out[e*NP +: NP] <= ph;
    endtask

    task automatic drop(input int e);
        @(posedge clk_in);
        fault_out[e]              <= 1'b0;
        fault_phase_out[e*NP +: NP] <= '0;
    endtask
endmodule

// ### dv/tb_general_protection_aggregator.sv
// testbench: directed checks of the protection aggregator
`timescale 1ns/1ps
module tb_general_protection_aggregator;
    logic                    clk_in = 1'b0;
    logic                    rstn_in = 1'b0;
    gpa_pkg::gpa_global_cfg_s cfg = '0;
    gpa_pkg::gpa_block_in_s  blk = '0;
    logic [3:0]              fn = 4'hf, sv = 4'h0, sp = 4'h1, pb = 4'h0, bi = 4'h0;
    logic [3:0]              fault;
    logic [11:0]             fph;
    logic [7:0]              addr = 8'h00;
    logic [31:0]             wdata = 32'h0000_0000, rdata;
    logic                    wr_s = 1'b0, rd_s = 1'b0, blocked, irq;
    logic [3:0]              alarm, trip, order;
    logic [1:0]              brk;
    logic [63:0]             dly = {4{16'h0006}};
    logic [7:0]              ba = 8'h01;
    gpa_pkg::gpa_collective_s coll;
    int                      error_cnt = 0;
    int                      n_checks = 0;

    always #20 clk_in = ~clk_in;

    gpa_fault_src i_gpa_fault_src (.clk_in(clk_in), .fault_out(fault), .fault_phase_out(fph));

    // short delay so the timer runs out within a few cycles
    gpa_aggregator i_gpa_aggregator (
        .clk_in(clk_in), .rstn_in(rstn_in), .global_cfg_in(cfg), .block_in(blk),
        .elem_function_in(fn), .elem_superv_only_in(sv), .elem_single_phase_in(sp),
        .elem_trip_order_perm_block_in(pb), .elem_trip_order_block_input_in(bi),
        .fault_in(fault), .fault_phase_in(fph), .delay_in(dly),
        .breaker_assign_in(ba), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_write_in(wr_s), .reg_read_in(rd_s), .reg_rdata_out(rdata),
        .elem_alarm_out(alarm), .elem_trip_out(trip), .trip_order_out(order),
        .collective_out(coll), .protection_blocked_out(blocked),
        .breaker_trip_out(brk), .irq_out(irq));

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t output got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        wr_s  <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk_in);
        wr_s  <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_in);
        rd_s <= 1'b1;
        addr <= a;
        @(posedge clk_in);
        rd_s <= 1'b0;
        #1;
        n_checks++;
        if (rdata !== exp) begin
            error_cnt++;
            $display("BAD %0t reg %h got %h exp %h", $time, a, rdata, exp);
        end
    endtask

    initial begin
        repeat (20000) @(posedge clk_in);
        error_cnt++;
        stop_test();
    end

    initial begin
        cfg.function_active = 1'b1;
        repeat (12) @(posedge clk_in);
        rstn_in <= 1'b1;
        cyc(1);
        chk(8'({alarm, trip}), 8'h00);
        chk(8'({order, brk, blocked, irq}), 8'h00);
        chk(8'(coll), 8'h00);
        rd_chk(8'h00, 32'h0000_0000);
        rd_chk(8'h04, 32'h0000_0000);
        $display("test reset done");

        i_gpa_fault_src.raise(0, 3'b010);
        cyc(4);
        chk(8'(alarm), 8'h01);
        chk(8'({coll.alarm, coll.alarm_phase}), 8'h0a);
        chk(8'(trip), 8'h00);
        cyc(8);
        chk(8'({trip, order}), 8'h11);
        chk(8'({coll.trip, coll.trip_phase}), 8'h0a);
        chk(8'(brk), 8'h01);
        rd_chk(8'h00, 32'h0000_0007);
        wr(8'h04, 32'h0000_0001);
        cyc(2);
        chk(8'(irq), 8'h01);
        wr(8'h00, 32'h0000_0001);
        rd_chk(8'h00, 32'h0000_0006);
        cyc(1);
        chk(8'(irq), 8'h00);
        rd_chk(8'h08, 32'h0000_0003);
        rd_chk(8'h0c, 32'h0000_0000);
        i_gpa_fault_src.drop(0);
        cyc(4);
        chk(8'({alarm, trip}), 8'h00);
        chk(8'({order, brk}), 8'h00);
        chk(8'({coll.alarm, coll.trip}), 8'h00);
        $display("test basic done");

        @(posedge clk_in) sv <= 4'b0010;
        sp <= 4'h3;
        i_gpa_fault_src.raise(1, 3'b100);
        cyc(12);
        chk(8'({alarm, trip}), 8'h22);
        chk(8'(order), 8'h00);
        chk(8'(coll), 8'h00);
        i_gpa_fault_src.drop(1);
        cyc(4);
        @(posedge clk_in) sv <= 4'h0;
        $display("test supervision done");

        i_gpa_fault_src.raise(2, 3'b001);
        cyc(12);
        chk(8'({trip, order}), 8'h44);
        chk(8'({coll.trip, coll.trip_phase}), 8'h08);
        @(posedge clk_in) cfg.trip_order_perm_block <= 1'b1;
        cyc(3);
        chk(8'({coll.trip, order}), 8'h10);
        @(posedge clk_in) cfg.trip_order_perm_block <= 1'b0;
        blk.trip_order_block_input <= 1'b1;
        cyc(3);
        chk(8'(order), 8'h04);
        @(posedge clk_in) cfg.trip_order_ext_block_permit <= 1'b1;
        cyc(3);
        chk(8'(order), 8'h00);
        @(posedge clk_in) blk.trip_order_block_input <= 1'b0;
        pb <= 4'b0100;
        cyc(3);
        chk(8'(order), 8'h00);
        @(posedge clk_in) pb <= 4'h0;
        bi <= 4'b0100;
        cyc(3);
        chk(8'(order), 8'h00);
        @(posedge clk_in) bi <= 4'h0;
        cyc(3);
        chk(8'(order), 8'h04);
        // move the order of element 2 onto the second breaker only
        @(posedge clk_in) ba <= 8'h40;
        cyc(3);
        chk(8'(brk), 8'h02);
        @(posedge clk_in) ba <= 8'h01;
        i_gpa_fault_src.drop(2);
        cyc(4);
        $display("test order blocks done");

        i_gpa_fault_src.raise(0, 3'b001);
        cyc(12);
        wr(8'h00, 32'h0000_000f);
        wr(8'h04, 32'h0000_0008);
        @(posedge clk_in) blk.block_input_a <= 1'b1;
        cyc(3);
        chk(8'({blocked, coll.trip}), 8'h01);
        @(posedge clk_in) cfg.external_block_permit <= 1'b1;
        cyc(3);
        chk(8'({blocked, alarm}), 8'h10);
        chk(8'({trip, order}), 8'h00);
        chk(8'({coll.alarm, coll.trip}), 8'h00);
        chk(8'(irq), 8'h01);
        rd_chk(8'h00, 32'h0000_0008);
        @(posedge clk_in) blk.block_input_a <= 1'b0;
        blk.block_input_b <= 1'b1;
        cyc(3);
        chk(8'(blocked), 8'h01);
        @(posedge clk_in) blk.block_input_b <= 1'b0;
        cyc(4);
        chk(8'({blocked, alarm}), 8'h01);
        @(posedge clk_in) cfg.function_active <= 1'b0;
        cyc(3);
        chk(8'({alarm, trip}), 8'h00);
        chk(8'(order), 8'h00);
        @(posedge clk_in) cfg.function_active <= 1'b1;
        fn <= 4'b1110;
        cyc(3);
        chk(8'({alarm, coll.alarm}), 8'h00);
        @(posedge clk_in) fn <= 4'hf;
        i_gpa_fault_src.drop(0);
        cyc(4);
        $display("test master block done");

        // timer must restart after a short dropout, not resume
        // dropout lands one cycle before expiry, so no trip may appear
        i_gpa_fault_src.raise(0, 3'b001);
        cyc(5);
        i_gpa_fault_src.drop(0);
        cyc(2);
        chk(8'(trip), 8'h00);
        i_gpa_fault_src.raise(0, 3'b001);
        cyc(7);
        chk(8'(trip), 8'h00);
        cyc(6);
        chk(8'(trip), 8'h01);
        i_gpa_fault_src.drop(0);
        cyc(4);
        chk(8'(trip), 8'h00);
        $display("test timer restart done");
        stop_test();
    end
endmodule
